// ---- hw/rsts_reset_strap.sv ----
// Power-on reset handling and boot strap sampling
// Functional notes
// - A low power_on_reset_n holds the block in reset, high lets it run.
// - Rising power_on_reset_n starts the self-configuration sequence.
// - In reset, LED selects, mirror enable/reset and link clock/data drive low.
// - In reset, every other output and two-way pin is high impedance.
// - Low mirror_park_request_n asks to park the mirror array, high un-parks.
// - Sampled host select low chooses SPI host port, high chooses I2C.
// - The port not chosen becomes the diagnostic monitoring port.
// - Straps stay undriven in reset and are sampled 1.5 us after release.
// - Each strap has a weak pull-down so an open strap reads low.
// - SPI mode strap low gives mode 0 or 3, high gives mode 1 or 2.
// - The SPI mode applies whatever role the host SPI port has.
// - A strap pin may become a debug output only after sampling.
`timescale 1ns/10ps
module rsts_reset_strap
    import rsts_pkg::*;
#(
    parameter int SAMPLE_CYCLES = STRAP_DELAY_CYCLES
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic power_on_reset_n,
    input  wire logic mirror_park_request_n,
    input  wire logic host_if_sel_in,
    input  wire logic host_spi_mode_in,
    input  wire logic debug_host_if_sel,
    input  wire logic debug_host_spi_mode,
    input  wire logic debug_drive_en,
    input  wire logic init_done,
    input  wire logic [3:0] led_select_req,
    input  wire logic mirror_enable_req,
    input  wire logic link_clock_req,
    input  wire logic link_data_req,
    input  wire logic gen_out_req,
    output logic      led_select_line_0,
    output logic      led_select_line_1,
    output logic      led_select_line_2,
    output logic      led_select_line_3,
    output logic      mirror_array_enable_reset_n,
    output logic      power_manager_link_clock,
    output logic      power_manager_link_data_out,
    output logic      gen_out,
    output logic      gen_out_oe,
    output logic      host_if_sel_out,
    output logic      host_if_sel_oe,
    output logic      host_spi_mode_out,
    output logic      host_spi_mode_oe,
    output logic      host_if_sel_pd_en,
    output logic      host_spi_mode_pd_en,
    output logic      init_start,
    output logic      in_reset,
    output logic      straps_valid,
    output logic      cmd_port_is_i2c,
    output logic      diag_port_is_i2c,
    output logic      spi_mode_alt,
    output logic      park_request
);

////////////////////////////////////////////////////////////////////////////
// Sequencer state

    rsts_state_t      state_r;
    rsts_state_t      state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             sel_r;
    logic             sel_nxt;
    logic             mode_r;
    logic             mode_nxt;
    logic             valid_r;
    logic             valid_nxt;
    logic             start_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        sel_nxt   = sel_r;
        mode_nxt  = mode_r;
        valid_nxt = valid_r;
        start_nxt = 1'h0;
        if (!power_on_reset_n)
        begin
            state_nxt = RSTS_WAIT;
            cnt_nxt   = '0;
            valid_nxt = 1'h0;
        end
        else
        begin
            case (state_r)
                RSTS_WAIT:
                begin
                    // Count from release so straps settle past reset edge
                    if (cnt_r == CNT_W'(SAMPLE_CYCLES - 1))
                    begin
                        sel_nxt   = host_if_sel_in;
                        mode_nxt  = host_spi_mode_in;
                        valid_nxt = 1'h1;
                        start_nxt = 1'h1;
                        state_nxt = RSTS_INIT;
                    end
                    else
                    begin
                        cnt_nxt = cnt_r + CNT_W'(1);
                    end
                end
                RSTS_INIT:
                begin
                    if (init_done)
                    begin
                        state_nxt = RSTS_RUN;
                    end
                end
                RSTS_RUN:
                begin
                    state_nxt = RSTS_RUN;
                end
                default:
                begin
                    state_nxt = RSTS_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= RSTS_WAIT;
            cnt_r   <= '0;
            sel_r   <= HOST_SEL_SPI;
            mode_r  <= SPI_MODE_0_3;
            valid_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            sel_r   <= sel_nxt;
            mode_r  <= mode_nxt;
            valid_r <= valid_nxt;
        end
    end

////////////////////////////////////////////////////////////////////////////
// Registered pin outputs

    logic       held;
    logic       dbg_ok;
    logic [3:0] led_nxt;
    logic       mirror_nxt;
    logic       lclk_nxt;
    logic       ldat_nxt;
    logic       gen_nxt;
    logic       gen_oe_nxt;
    logic       sel_out_nxt;
    logic       mode_out_nxt;
    logic       pd_nxt;
    logic       diag_nxt;
    logic       park_nxt;

    always_comb
    begin
        held         = !power_on_reset_n;
        // Debug drive only after latch, never before sampling
        dbg_ok       = valid_r && power_on_reset_n && debug_drive_en;
        // Forced low in reset; board pull-downs cover power-up before this
        led_nxt      = held ? {4{PIN_LOW}} : led_select_req;
        mirror_nxt   = held ? PIN_LOW : mirror_enable_req;
        lclk_nxt     = held ? PIN_LOW : link_clock_req;
        ldat_nxt     = held ? PIN_LOW : link_data_req;
        gen_nxt      = held ? PIN_LOW : gen_out_req;
        gen_oe_nxt   = !held;
        sel_out_nxt  = dbg_ok ? debug_host_if_sel : PIN_LOW;
        mode_out_nxt = dbg_ok ? debug_host_spi_mode : PIN_LOW;
        // Pull-down kept whenever not driving, so open straps read low
        pd_nxt       = !dbg_ok;
        diag_nxt     = !sel_nxt;
        park_nxt     = mirror_park_request_n == PARK_ACTIVE;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_select_line_0           <= PIN_LOW;
            led_select_line_1           <= PIN_LOW;
            led_select_line_2           <= PIN_LOW;
            led_select_line_3           <= PIN_LOW;
            mirror_array_enable_reset_n <= PIN_LOW;
            power_manager_link_clock    <= PIN_LOW;
            power_manager_link_data_out <= PIN_LOW;
            gen_out                     <= PIN_LOW;
            gen_out_oe                  <= 1'h0;
            host_if_sel_out             <= PIN_LOW;
            host_if_sel_oe              <= 1'h0;
            host_spi_mode_out           <= PIN_LOW;
            host_spi_mode_oe            <= 1'h0;
            host_if_sel_pd_en           <= 1'h1;
            host_spi_mode_pd_en         <= 1'h1;
            init_start                  <= 1'h0;
            in_reset                    <= 1'h1;
            straps_valid                <= 1'h0;
            cmd_port_is_i2c             <= HOST_SEL_SPI;
            diag_port_is_i2c            <= HOST_SEL_I2C;
            spi_mode_alt                <= SPI_MODE_0_3;
            park_request                <= 1'h0;
        end
        else
        begin
            led_select_line_0           <= led_nxt[0];
            led_select_line_1           <= led_nxt[1];
            led_select_line_2           <= led_nxt[2];
            led_select_line_3           <= led_nxt[3];
            mirror_array_enable_reset_n <= mirror_nxt;
            power_manager_link_clock    <= lclk_nxt;
            power_manager_link_data_out <= ldat_nxt;
            gen_out                     <= gen_nxt;
            gen_out_oe                  <= gen_oe_nxt;
            host_if_sel_out             <= sel_out_nxt;
            host_if_sel_oe              <= dbg_ok;
            host_spi_mode_out           <= mode_out_nxt;
            host_spi_mode_oe            <= dbg_ok;
            host_if_sel_pd_en           <= pd_nxt;
            host_spi_mode_pd_en         <= pd_nxt;
            init_start                  <= start_nxt;
            in_reset                    <= held;
            straps_valid                <= valid_nxt;
            cmd_port_is_i2c             <= sel_nxt;
            diag_port_is_i2c            <= diag_nxt;
            spi_mode_alt                <= mode_nxt;
            park_request                <= park_nxt;
        end
    end

endmodule

// ---- common/rsts_pkg.sv ----
// Constants and types for reset handling and strap sampling
package rsts_pkg;
    // Strap sample delay after reset release
    localparam int STRAP_DELAY_NS     = 1500;
    localparam int CLK_PERIOD_NS      = 10;
    localparam int STRAP_DELAY_CYCLES = STRAP_DELAY_NS / CLK_PERIOD_NS;
    localparam int CNT_W              = 8;

    // Strap encodings
    localparam logic HOST_SEL_SPI     = 1'h0;
    localparam logic HOST_SEL_I2C     = 1'h1;
    localparam logic SPI_MODE_0_3     = 1'h0;
    localparam logic SPI_MODE_1_2     = 1'h1;

    // Pin levels while in reset, and the active park request level
    localparam logic PIN_LOW          = 1'h0;
    localparam logic PARK_ACTIVE      = 1'h0;

    typedef enum logic [2:0]
    {
        RSTS_WAIT  = 3'h1,
        RSTS_INIT  = 3'h2,
        RSTS_RUN   = 3'h4
    } rsts_state_t;
endpackage

// ---- dv/rsts_reset_strap_assertions.sv ----
// Concurrent checks on reset pins and strap sampling
`timescale 1ns/10ps
module rsts_checker
    import rsts_pkg::*;
#(
    parameter int SAMPLE_CYCLES = STRAP_DELAY_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic power_on_reset_n,
    input wire logic mirror_park_request_n,
    input wire logic host_if_sel_in,
    input wire logic host_spi_mode_in,
    input wire logic debug_drive_en,
    input wire logic led_select_line_0,
    input wire logic mirror_array_enable_reset_n,
    input wire logic power_manager_link_clock,
    input wire logic gen_out_oe,
    input wire logic host_if_sel_oe,
    input wire logic init_start,
    input wire logic straps_valid,
    input wire logic cmd_port_is_i2c,
    input wire logic spi_mode_alt,
    input wire logic park_request
);
    // First high edge counts as one, so the pulse lands exactly
    localparam int SLO = SAMPLE_CYCLES;
    localparam int SHI = SAMPLE_CYCLES;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence rel_s; $rose(power_on_reset_n); endsequence
    sequence smp_s; ##[SLO:SHI] init_start; endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_pins_low:
        assert property (!power_on_reset_n |=> !(led_select_line_0
        | mirror_array_enable_reset_n | power_manager_link_clock))
        else $error("pins not low in reset");
    chk_hiz_reset:
        assert property (!power_on_reset_n |=> !gen_out_oe && !host_if_sel_oe)
        else $error("pin driven in reset");
    chk_sample_time:
        assert property (disable iff (!rst_n || !power_on_reset_n)
        rel_s |-> smp_s) else $error("strap sample late");
    chk_init_pulse:
        assert property (init_start |=> !init_start)
        else $error("init start not a pulse");
    chk_strap_val:
        assert property ($rose(straps_valid) |-> cmd_port_is_i2c ==
        $past(host_if_sel_in) && spi_mode_alt == $past(host_spi_mode_in))
        else $error("strap value wrong");
    chk_straps_hold:
        assert property (straps_valid && $past(straps_valid) |->
        $stable(cmd_port_is_i2c) && $stable(spi_mode_alt))
        else $error("strap changed");
    chk_dbg_gate:
        assert property (host_if_sel_oe |-> straps_valid
        && $past(debug_drive_en)) else $error("strap driven early");
    chk_park_map:
        assert property (park_request == !$past(mirror_park_request_n))
        else $error("park wrong");
endmodule

// ---- dv/rsts_pmic_model.sv ----
// Power manager model driving reset and park
`timescale 1ns/10ps
module rsts_pmic_model (
    input  wire logic ref_clk,
    input  wire logic supplies_ok,
    input  wire logic power_loss,
    output logic      power_on_reset_n,
    output logic      mirror_park_request_n
);
    // One process owns both lines; reset starts low, park released
    initial
    begin
        power_on_reset_n = 1'h0;
        mirror_park_request_n = 1'h1;
        forever
        begin
            @(posedge ref_clk);
            // Release only once supplies and clocks have settled
            power_on_reset_n <= supplies_ok;
            mirror_park_request_n <= !power_loss;
        end
    end
endmodule

// ---- dv/rsts_reset_strap_test.sv ----
// Self-checking bench for reset and strap sampling
`timescale 1ns/10ps
module rsts_reset_strap_test;
    localparam int SAMPLE_CYCLES = 4;
    logic ref_clk = 1'h0, rst_n = 1'h0, supplies_ok = 1'h0, power_loss = 1'h0;
    logic debug_host_if_sel = 1'h1, debug_host_spi_mode = 1'h1;
    logic debug_drive_en = 1'h1, init_done = 1'h0, gen_out_req = 1'h1;
    logic [3:0] led_select_req = 4'hF;
    logic mirror_enable_req = 1'h1, link_clock_req = 1'h1, link_data_req = 1'h1;
    logic brd_drv = 1'h0, brd_sel = 1'h0, brd_mode = 1'h0;
    logic power_on_reset_n, mirror_park_request_n;
    logic host_if_sel_in, host_spi_mode_in, led_select_line_0;
    logic led_select_line_1, led_select_line_2, led_select_line_3;
    logic mirror_array_enable_reset_n, power_manager_link_clock;
    logic power_manager_link_data_out, gen_out, gen_out_oe, host_if_sel_out;
    logic host_if_sel_oe, host_spi_mode_out, host_spi_mode_oe;
    logic host_if_sel_pd_en, host_spi_mode_pd_en, init_start, in_reset;
    logic straps_valid, cmd_port_is_i2c, diag_port_is_i2c, spi_mode_alt;
    logic park_request;
    logic led_pin_0, gen_pin;
    int fails = 0, tests_run = 0;
    // Strap pin: device drive, else board, else weak pull-down
    assign host_if_sel_in = host_if_sel_oe ? host_if_sel_out
                          : (brd_drv ? brd_sel : 1'h0);
    assign host_spi_mode_in = host_spi_mode_oe ? host_spi_mode_out
                            : (brd_drv ? brd_mode : 1'h0);
    // Board pull-downs: an undriven or unknown line reads low
    assign led_pin_0 = (led_select_line_0 === 1'h1);
    assign gen_pin = gen_out_oe ? gen_out : 1'h0;
    always #5 ref_clk = ~ref_clk;
    rsts_reset_strap #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_rsts_reset_strap (.*);
    rsts_pmic_model i_rsts_pmic_model (.*);
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string what, logic exp, logic got);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1;
        check("led pin", 1'h0, led_pin_0);
        step(6);
        rst_n <= 1'h1;
        step(2);
        check("led", 1'h0, led_select_line_0);
        check("link", 1'h0, power_manager_link_data_out);
        check("mirror", 1'h0, mirror_array_enable_reset_n);
        check("gen oe", 1'h0, gen_out_oe);
        check("gen pin", 1'h0, gen_pin);
        check("dbg early", 1'h0, host_if_sel_oe);
        check("pd", 1'h1, host_if_sel_pd_en);
        $display("test reset pins done");
        for (int i = 0; i < 4; i++)
        begin
            brd_drv <= (i != 0);
            brd_sel <= i[1];
            brd_mode <= i[0];
            supplies_ok <= 1'h1;
            // One edge in the model, then the design's own count
            step(SAMPLE_CYCLES + 1);
            check("early", 1'h0, straps_valid);
            check("no init", 1'h0, init_start);
            step(1);
            check("valid", 1'h1, straps_valid);
            check("init", 1'h1, init_start);
            check("cmd", i[1], cmd_port_is_i2c);
            check("diag", !i[1], diag_port_is_i2c);
            check("mode", i[0], spi_mode_alt);
            check("led", 1'h1, led_select_line_0);
            check("link clk", 1'h1, power_manager_link_clock);
            check("gen run", 1'h1, gen_pin);
            check("no drive", 1'h0, host_if_sel_oe);
            brd_sel <= !i[1];
            brd_mode <= !i[0];
            step(2);
            check("pulse", 1'h0, init_start);
            check("hold", i[1], cmd_port_is_i2c);
            check("hold mode", i[0], spi_mode_alt);
            check("dbg oe", 1'h1, host_if_sel_oe);
            check("dbg out", 1'h1, host_spi_mode_out);
            check("pd off", 1'h0, host_spi_mode_pd_en);
            supplies_ok <= 1'h0;
            step(3);
            check("rst", 1'h0, straps_valid);
            check("rst oe", 1'h0, host_if_sel_oe);
            check("rst pd", 1'h1, host_spi_mode_pd_en);
            check("rst led", 1'h0, led_select_line_3);
            check("in rst", 1'h1, in_reset);
            $display("test strap %0d done", i);
        end
        power_loss <= 1'h1;
        step(3);
        check("park", 1'h1, park_request);
        power_loss <= 1'h0;
        step(3);
        check("unpark", 1'h0, park_request);
        $display("test park done");
        conclude();
    end
    // Whole run needs about 60 cycles; a thousand means a hang
    initial
    begin
        step(1000);
        fails++;
        conclude();
    end
endmodule
bind rsts_reset_strap rsts_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES))
    i_rsts_checker (.*);
